/* shared/mode_policy_pkg.sv */
// Package with modes, commands, address ranges and reset values of the mode controller.
package mode_policy_pkg;

  // ==========================================================================
  // Operating modes and requests
  // ==========================================================================
  typedef enum logic [1:0] {
    MODE_PROGRAM,
    MODE_MONITOR,
    MODE_RUN
  } op_mode_type;

  typedef enum logic [2:0] {
    ACC_READ_MEM,
    ACC_WRITE_MEM,
    ACC_FORCE_BIT,
    ACC_ONLINE_EDIT,
    ACC_WRITE_PROG,
    ACC_WRITE_ALLOC
  } access_type;

  typedef enum logic [1:0] {
    REF_CYCLE,
    REF_INSTRUCTION,
    REF_INTERRUPT_IN,
    REF_IMMEDIATE_OUT
  } refresh_type;

  // ==========================================================================
  // Register offsets
  // ==========================================================================
  localparam logic [3:0] OFF_MODE_CTRL   = 4'h0;
  localparam logic [3:0] OFF_MODE_STAT   = 4'h1;
  localparam logic [3:0] OFF_SYS_CTRL    = 4'h2;
  localparam logic [3:0] OFF_ERR_COUNT   = 4'h3;
  localparam logic [3:0] OFF_CYCLE_COUNT = 4'h4;

  // ==========================================================================
  // Field positions and reset values
  // ==========================================================================
  localparam int         POS_REQ_VALID   = 2;
  localparam int         POS_IO_HOLD     = 0;
  localparam int         POS_FATAL_CLR   = 1;
  localparam logic [1:0] MODE_RESET      = 2'h0;
  localparam logic [3:0] ERR_LOG_DEPTH   = 4'hA;
  localparam logic [7:0] EXPLICIT_REFRESH_CODE = 8'h61;
  localparam logic [7:0] FATAL_ALARM_CODE      = 8'h07;

  // ==========================================================================
  // Data memory ranges
  // ==========================================================================
  localparam logic [15:0] RO_AREA_FIRST  = 16'h1800;
  localparam logic [15:0] RO_AREA_LAST   = 16'h19A8;
  localparam logic [15:0] ERR_LOG_FIRST  = 16'h19A9;
  localparam logic [15:0] ERR_LOG_LAST   = 16'h19C7;
  localparam logic [15:0] SETUP_FIRST    = 16'h19C8;
  localparam logic [15:0] SETUP_LAST     = 16'h19FF;
  localparam logic [15:0] IO_HOLD_BIT_NO = 16'h627C;
  localparam logic [15:0] CLEAR_DONE     = 16'h0000;

endpackage

/* src/mode_policy.sv */
// Operating mode controller: cycle sequencing, memory clear policy and access guard.
`timescale 1ns/1ps
// Function
// R1: Three modes program, monitor, run; program mode halts the user program.
// R2: I/O refresh keeps running every cycle while in program mode.
// R3: Monitor mode runs the program and accepts edits, forcing and memory writes.
// R4: Run mode rejects edits, forcing and memory writes; reads stay allowed. The run-mode check exempts the read-only and setup areas.
// R5: Program to run or monitor and back clears non-held areas; run-monitor keeps all.
// R6: Leaving run or monitor for program keeps timer values and completion flags.
// R7: Entering run or monitor from program clears timer values and completion flags.
// R8: With the I/O hold bit set no mode change clears I/O memory.
// R9: Fatal stop with I/O hold set keeps I/O memory but forces all outputs off.
// R10: Instructions run in order; after the last, all units refresh, then restart.
// R11: Unit data exchange only per cycle, refresh instruction, interrupt input, immediate out.
// R12: Write protect switch 1 on refuses programming device writes to the program.
// R13: Read-only words: program reads only; device writes only while unprotected.
// R14: Error log holds time and code of errors, ten entries at most.
// R15: Switch 4 off uses default allocations and rejects allocation changes.
// R16: Switch 2 on at power-up copies cassette contents into the CPU.
// R17: An attached terminal on the dedicated link never changes the mode.
// R18: Terminal write over host protocol in run mode switches the device to monitor.
// R19: Mode changes and their clears take effect only at cycle boundaries.
module mode_policy
  import mode_policy_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic [3:0]  reg_addr_in,
  input  wire logic [15:0] reg_wdata_in,
  input  wire logic        reg_write_in,
  input  wire logic        reg_read_in,
  output logic      [15:0] reg_rdata_out,
  input  wire logic        protect_sw_in,
  input  wire logic        cassette_sw_in,
  input  wire logic        alloc_sw_in,
  input  wire logic        last_instr_in,
  input  wire logic        refresh_instr_in,
  input  wire logic        interrupt_in,
  input  wire logic        immediate_out_in,
  input  wire logic        fatal_in,
  input  wire logic        error_in,
  input  wire logic        acc_valid_in,
  input  wire logic [2:0]  acc_kind_in,
  input  wire logic [15:0] acc_addr_in,
  input  wire logic        acc_from_program_in,
  input  wire logic        terminal_link_in,
  input  wire logic        terminal_host_write_in,
  output logic             acc_grant_out,
  output logic             acc_reject_out,
  output logic             execute_out,
  output logic             refresh_out,
  output logic      [1:0]  refresh_kind_out,
  output logic             clear_non_held_out,
  output logic             clear_timers_out,
  output logic             outputs_off_out,
  output logic             log_write_out,
  output logic      [3:0]  log_slot_out,
  output logic             cassette_load_out,
  output logic             default_alloc_out,
  output logic      [1:0]  mode_out
);

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  logic [3:0] sw_meta_r;
  logic [3:0] sw_sync_r;
  always_ff @(posedge clk_in) begin
    sw_meta_r <= {terminal_link_in, alloc_sw_in, cassette_sw_in, protect_sw_in};
    sw_sync_r <= sw_meta_r;
  end
  wire logic protect_on = sw_sync_r[0];
  wire logic cassette_on = sw_sync_r[1];
  wire logic alloc_on = sw_sync_r[2];
  wire logic terminal_on = sw_sync_r[3];

  // ==========================================================================
  // Mode state and pending request
  // ==========================================================================
  op_mode_type mode_r;
  op_mode_type pend_mode_r;
  logic        pend_r;
  logic        io_hold_r;
  logic        fatal_r;
  logic        boot_r;
  logic [3:0]  log_count_r;
  logic [15:0] cycle_count_r;

  wire logic        wr_mode = reg_write_in && (reg_addr_in == OFF_MODE_CTRL);
  wire logic        wr_sys = reg_write_in && (reg_addr_in == OFF_SYS_CTRL);
  wire op_mode_type req_mode = op_mode_type'(reg_wdata_in[1:0]);
  wire logic        req_legal = (reg_wdata_in[1:0] != 2'h3);
  wire logic        sw_req = wr_mode && reg_wdata_in[POS_REQ_VALID] && req_legal
                             && !terminal_on; // R17
  wire logic        auto_req = terminal_host_write_in && (mode_r == MODE_RUN) // R18
                               && !terminal_on; // R17
  wire logic        boundary = last_instr_in || (mode_r == MODE_PROGRAM);
  wire logic        running = (mode_r != MODE_PROGRAM) && !fatal_r;
  wire logic        pend_prog = (pend_mode_r == MODE_PROGRAM);
  wire logic        cur_prog = (mode_r == MODE_PROGRAM);
  wire logic        apply = pend_r && boundary; // R19
  wire logic        crosses = apply && (pend_prog != cur_prog); // R5

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mode_r      <= MODE_PROGRAM;
      pend_mode_r <= MODE_PROGRAM;
      pend_r      <= 1'b0;
    end else begin
      if (apply) begin
        mode_r <= pend_mode_r; // R1
      end
      if (sw_req) begin
        pend_mode_r <= req_mode;
        pend_r      <= 1'b1;
      end else if (auto_req) begin
        pend_mode_r <= MODE_MONITOR;
        pend_r      <= 1'b1;
      end else if (apply) begin
        pend_r <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // System control, fatal stop, boot and error log
  // ==========================================================================
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      io_hold_r     <= 1'b0;
      fatal_r       <= 1'b0;
      boot_r        <= 1'b1;
      log_count_r   <= 4'h0;
      cycle_count_r <= 16'h0000;
    end else begin
      if (wr_sys) begin
        io_hold_r <= reg_wdata_in[POS_IO_HOLD];
      end
      if (fatal_in) begin
        fatal_r <= 1'b1;
      end else if (wr_sys && reg_wdata_in[POS_FATAL_CLR]) begin
        fatal_r <= 1'b0;
      end
      boot_r <= 1'b0;
      if ((error_in || fatal_in) && (log_count_r != ERR_LOG_DEPTH)) begin
        log_count_r <= log_count_r + 4'h1; // R14
      end
      if (last_instr_in || cur_prog) begin
        cycle_count_r <= cycle_count_r + 16'h0001;
      end
    end
  end

  // ==========================================================================
  // Access guard
  // ==========================================================================
  wire logic in_ro = (acc_addr_in >= RO_AREA_FIRST) && (acc_addr_in <= RO_AREA_LAST);
  wire logic in_setup = (acc_addr_in >= SETUP_FIRST) && (acc_addr_in <= SETUP_LAST);
  wire logic is_read = (acc_kind_in == ACC_READ_MEM);
  wire logic mem_wr = (acc_kind_in == ACC_WRITE_MEM);
  wire logic alter = (acc_kind_in == ACC_FORCE_BIT) || (acc_kind_in == ACC_ONLINE_EDIT)
                     || mem_wr;
  wire logic deny_run = alter && (mode_r == MODE_RUN) && !in_ro && !in_setup; // R4
  wire logic deny_prog = (acc_kind_in == ACC_WRITE_PROG) && protect_on; // R12
  wire logic deny_ro = mem_wr && (in_ro || in_setup)
                       && (acc_from_program_in ? in_ro : protect_on); // R13
  wire logic deny_alloc = (acc_kind_in == ACC_WRITE_ALLOC) && !alloc_on; // R15
  wire logic deny_any = !is_read && (deny_run || deny_prog || deny_ro || deny_alloc);

  assign acc_grant_out = acc_valid_in && !deny_any; // R3
  assign acc_reject_out = acc_valid_in && deny_any;

  // ==========================================================================
  // Cycle, refresh and clear outputs
  // ==========================================================================
  wire logic refresh_cycle = last_instr_in || cur_prog; // R2
  wire logic refresh_any = refresh_cycle || (running && refresh_instr_in) || interrupt_in
                           || (running && immediate_out_in); // R11
  wire logic [1:0] refresh_kind = refresh_cycle ? 2'(REF_CYCLE) :
                                  (running && refresh_instr_in) ? 2'(REF_INSTRUCTION) :
                                  interrupt_in ? 2'(REF_INTERRUPT_IN) : 2'(REF_IMMEDIATE_OUT);

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      execute_out        <= 1'b0;
      refresh_out        <= 1'b0;
      refresh_kind_out   <= 2'h0;
      clear_non_held_out <= 1'b0;
      clear_timers_out   <= 1'b0;
      outputs_off_out    <= 1'b0;
      log_write_out      <= 1'b0;
      log_slot_out       <= 4'h0;
      cassette_load_out  <= 1'b0;
      default_alloc_out  <= 1'b1;
      mode_out           <= MODE_RESET;
    end else begin
      execute_out        <= running && !(apply && pend_prog); // R10
      refresh_out        <= refresh_any;
      refresh_kind_out   <= refresh_kind;
      clear_non_held_out <= crosses && !io_hold_r; // R8
      clear_timers_out   <= crosses && cur_prog && !io_hold_r; // R6 R7
      outputs_off_out    <= fatal_r && io_hold_r; // R9
      log_write_out      <= (error_in || fatal_in) && (log_count_r != ERR_LOG_DEPTH);
      log_slot_out       <= log_count_r;
      cassette_load_out  <= boot_r && cassette_on; // R16
      default_alloc_out  <= !alloc_on;
      mode_out           <= apply ? 2'(pend_mode_r) : 2'(mode_r);
    end
  end

  // ==========================================================================
  // Register read port
  // ==========================================================================
  wire logic [15:0] rd_mux = (reg_addr_in == OFF_MODE_CTRL) ? {13'h0, pend_r, 2'(pend_mode_r)} :
                             (reg_addr_in == OFF_MODE_STAT) ? {13'h0, fatal_r, 2'(mode_r)} :
                             (reg_addr_in == OFF_SYS_CTRL) ? {14'h0, fatal_r, io_hold_r} :
                             (reg_addr_in == OFF_ERR_COUNT) ? {12'h0, log_count_r} :
                             (reg_addr_in == OFF_CYCLE_COUNT) ? cycle_count_r : 16'h0000;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      reg_rdata_out <= 16'h0000;
    end else begin
      reg_rdata_out <= reg_read_in ? rd_mux : 16'h0000;
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  sequence s_cross_to_prog;
    crosses && !cur_prog && !io_hold_r;
  endsequence

  chk_run_rejects_force: assert property (@(posedge clk_in) disable iff (rst_in) // R4
    (acc_valid_in && mode_r == MODE_RUN && acc_kind_in == ACC_FORCE_BIT && !in_ro && !in_setup)
      |-> acc_reject_out && !acc_grant_out)
    else $error("force access granted in run mode");
  chk_monitor_accepts: assert property (@(posedge clk_in) disable iff (rst_in) // R3
    (acc_valid_in && mode_r == MODE_MONITOR && acc_kind_in == ACC_ONLINE_EDIT) |-> acc_grant_out)
    else $error("online edit refused in monitor mode");
  chk_prog_protect: assert property (@(posedge clk_in) disable iff (rst_in) // R12
    (acc_valid_in && protect_on && acc_kind_in == ACC_WRITE_PROG) |-> !acc_grant_out)
    else $error("program write granted while protected");
  chk_timers_kept: assert property (@(posedge clk_in) disable iff (rst_in) // R6
    s_cross_to_prog |=> clear_non_held_out && !clear_timers_out)
    else $error("timers cleared on change to program mode");
  chk_hold_no_clear: assert property (@(posedge clk_in) disable iff (rst_in) // R8
    $past(io_hold_r) |-> !clear_non_held_out)
    else $error("clear issued while io hold set");
  chk_mode_boundary: assert property (@(posedge clk_in) disable iff (rst_in) // R19
    (mode_r != $past(mode_r)) |-> $past(boundary))
    else $error("mode changed mid cycle");
  chk_terminal_fixed: assert property (@(posedge clk_in) disable iff (rst_in) // R17
    (terminal_on && !pend_r) |=> !pend_r)
    else $error("mode request taken with terminal link");
  chk_log_limit: assert property (@(posedge clk_in) disable iff (rst_in) // R14
    log_count_r <= ERR_LOG_DEPTH)
    else $error("error log above ten entries");
  chk_run_to_monitor: assert property (@(posedge clk_in) disable iff (rst_in) // R18
    (auto_req && !sw_req) |=> pend_r && pend_mode_r == MODE_MONITOR)
    else $error("terminal write did not request monitor mode");
  chk_prog_halt: assert property (@(posedge clk_in) disable iff (rst_in) // R1
    cur_prog |=> !execute_out ##0 refresh_out)
    else $error("program mode executed or missed refresh");

  // Clears on entry to run or monitor, and the single load pulse after reset.
  sequence s_cross_from_prog;
    crosses && cur_prog && !io_hold_r;
  endsequence

  sequence s_boot_load;
    boot_r && cassette_on;
  endsequence

  chk_entry_clears: assert property (@(posedge clk_in) disable iff (rst_in) // R7
    s_cross_from_prog |=> clear_non_held_out && clear_timers_out)
    else $error("timers not cleared on entry to run or monitor");
  chk_run_monitor_keep: assert property (@(posedge clk_in) disable iff (rst_in) // R5
    (apply && !pend_prog && !cur_prog) |=> !clear_non_held_out && !clear_timers_out)
    else $error("clear issued on change between run and monitor");
  chk_outputs_off: assert property (@(posedge clk_in) disable iff (rst_in) // R9
    (fatal_r && io_hold_r) |=> outputs_off_out)
    else $error("outputs left on after fatal stop with io hold");
  chk_cycle_restart: assert property (@(posedge clk_in) disable iff (rst_in) // R10
    (running && last_instr_in && !pend_r) |=> refresh_out && execute_out
      && (refresh_kind_out == 2'(REF_CYCLE)))
    else $error("no full refresh after the last instruction");
  chk_refresh_points: assert property (@(posedge clk_in) disable iff (rst_in) // R11
    !(last_instr_in || cur_prog || refresh_instr_in || interrupt_in || immediate_out_in)
      |=> !refresh_out)
    else $error("refresh outside the allowed points");
  chk_ro_guard: assert property (@(posedge clk_in) disable iff (rst_in) // R13
    (acc_valid_in && mem_wr && acc_from_program_in && in_ro)
      |-> acc_reject_out && !acc_grant_out)
    else $error("program write to read-only words granted");
  chk_alloc_default: assert property (@(posedge clk_in) disable iff (rst_in) // R15
    (acc_valid_in && !alloc_on && acc_kind_in == ACC_WRITE_ALLOC) |-> acc_reject_out)
    else $error("allocation change granted with default allocations");
  chk_log_full: assert property (@(posedge clk_in) disable iff (rst_in) // R14
    (log_count_r == ERR_LOG_DEPTH) |=> !log_write_out)
    else $error("error log written while full");
  chk_cassette_load: assert property (@(posedge clk_in) disable iff (rst_in) // R16
    s_boot_load |=> cassette_load_out)
    else $error("cassette load missing after reset");
  chk_cassette_once: assert property (@(posedge clk_in) disable iff (rst_in) // R16
    !boot_r |=> !cassette_load_out)
    else $error("cassette load outside the first cycle");
  chk_mode_applied: assert property (@(posedge clk_in) disable iff (rst_in) // R19
    apply |=> (mode_out == $past(pend_mode_r)))
    else $error("applied mode not shown on mode output");

endmodule // mode_policy

/* verif/prog_device_model.sv */
// Programming device model that issues program and memory access requests.
`timescale 1ns/1ps
module prog_device_model
  import mode_policy_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        grant_in,
  input  wire logic        reject_in,
  output logic             valid_out,
  output logic      [2:0]  kind_out,
  output logic      [15:0] addr_out,
  output logic             from_program_out
);
  initial begin
    valid_out = 1'b0;
    kind_out = 3'h0;
    addr_out = 16'h0000;
    from_program_out = 1'b0;
  end

  // Holds the request for one edge, takes the answer there, then scrambles the idle lines.
  task request(input access_type k, input logic [15:0] a, input logic p,
               output logic g, output logic r);
    @(posedge clk_in);
    valid_out <= 1'b1;
    kind_out <= k;
    addr_out <= a;
    from_program_out <= p;
    @(posedge clk_in);
    g = grant_in;
    r = reject_in;
    valid_out <= 1'b0;
    kind_out <= ~k;
    addr_out <= ~a;
    from_program_out <= ~p;
  endtask
endmodule // prog_device_model

/* verif/tb_mode_policy.sv */
// Self-checking testbench for the operating mode controller.
`timescale 1ns/1ps
module tb_mode_policy
  import mode_policy_pkg::*;
;
  logic        clk_in = 1'b0, rst_in = 1'b1, reg_write_in = 1'b0, reg_read_in = 1'b0;
  logic        protect_sw_in = 1'b0, cassette_sw_in = 1'b0, alloc_sw_in = 1'b0;
  logic        terminal_link_in = 1'b0;
  logic [3:0]  reg_addr_in = 4'h0;
  logic [15:0] reg_wdata_in = 16'h0000;
  logic [6:0]  ev = 7'h00;
  logic        last_instr_in, refresh_instr_in, interrupt_in, immediate_out_in;
  logic        fatal_in, error_in, terminal_host_write_in;
  logic        acc_valid_in, acc_from_program_in, acc_grant_out, acc_reject_out;
  logic [2:0]  acc_kind_in;
  logic [15:0] acc_addr_in, reg_rdata_out, rd;
  logic        execute_out, refresh_out, clear_non_held_out, clear_timers_out;
  logic        outputs_off_out, log_write_out, cassette_load_out, default_alloc_out;
  logic [1:0]  refresh_kind_out, mode_out;
  logic [3:0]  log_slot_out;
  logic        g, r, nh, tc;
  int          fail_count = 0;
  int          check_count = 0;

  assign {terminal_host_write_in, error_in, fatal_in, immediate_out_in, interrupt_in,
          refresh_instr_in, last_instr_in} = ev;

  always #2.5 clk_in = ~clk_in;

  mode_policy dut (.clk_in, .rst_in, .reg_addr_in, .reg_wdata_in, .reg_write_in,
    .reg_read_in, .reg_rdata_out, .protect_sw_in, .cassette_sw_in, .alloc_sw_in,
    .last_instr_in, .refresh_instr_in, .interrupt_in, .immediate_out_in, .fatal_in,
    .error_in, .acc_valid_in, .acc_kind_in, .acc_addr_in, .acc_from_program_in,
    .terminal_link_in, .terminal_host_write_in, .acc_grant_out, .acc_reject_out,
    .execute_out, .refresh_out, .refresh_kind_out, .clear_non_held_out, .clear_timers_out,
    .outputs_off_out, .log_write_out, .log_slot_out, .cassette_load_out,
    .default_alloc_out, .mode_out);

  prog_device_model pdev (.clk_in, .grant_in(acc_grant_out), .reject_in(acc_reject_out),
    .valid_out(acc_valid_in), .kind_out(acc_kind_in), .addr_out(acc_addr_in),
    .from_program_out(acc_from_program_in));

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task stop_test;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_in);
    reg_write_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clk_in);
    reg_write_in <= 1'b0;
  endtask

  task reg_rd(input logic [3:0] a);
    @(posedge clk_in);
    reg_read_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_in);
    reg_read_in <= 1'b0;
    #1;
    rd = reg_rdata_out;
  endtask

  task pulse(input int b);
    @(posedge clk_in);
    ev[b] <= 1'b1;
    @(posedge clk_in);
    ev[b] <= 1'b0;
    #1;
  endtask

  task acc(input access_type k, input logic [15:0] a, input logic p, input logic [1:0] e);
    pdev.request(k, a, p, g, r);
    check(16'({g, r}), 16'(e));
  endtask

  task wait_cycles(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  // Requests a mode, gives one cycle boundary and records any clear pulses.
  task go(input logic [1:0] m);
    nh = 1'b0;
    tc = 1'b0;
    reg_wr(OFF_MODE_CTRL, {13'h0000, 1'b1, m});
    @(posedge clk_in);
    ev[0] <= 1'b1;
    repeat (4) begin
      #1;
      nh |= clear_non_held_out;
      tc |= clear_timers_out;
      @(posedge clk_in);
      ev[0] <= 1'b0;
    end
    #1;
    check(16'(mode_out), 16'(m));
  endtask

  task term(input logic link, input logic [1:0] exp);
    go(MODE_RUN);
    @(posedge clk_in);
    terminal_link_in <= link;
    wait_cycles(3);
    pulse(6);
    if (link) begin
      reg_wr(OFF_MODE_CTRL, 16'h0004);
    end
    pulse(0);
    wait_cycles(2);
    check(16'(mode_out), 16'(exp));
    @(posedge clk_in);
    terminal_link_in <= 1'b0;
    wait_cycles(3);
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task t_program;
    wait_cycles(3);
    check(16'({mode_out, execute_out}), 16'h0000);
    check(16'({refresh_out, refresh_kind_out}), 16'h0004);
    check(16'(default_alloc_out), 16'h0001);
    reg_rd(4'hF);
    check(rd, 16'h0000);
    acc(ACC_WRITE_PROG, 16'h0000, 1'b0, 2'b10);
    acc(ACC_WRITE_MEM, RO_AREA_LAST, 1'b0, 2'b10);
    acc(ACC_WRITE_MEM, RO_AREA_FIRST, 1'b1, 2'b01);
    acc(ACC_READ_MEM, RO_AREA_FIRST, 1'b1, 2'b10);
    acc(ACC_WRITE_ALLOC, 16'h0000, 1'b0, 2'b01);
    @(posedge clk_in);
    protect_sw_in <= 1'b1;
    alloc_sw_in <= 1'b1;
    wait_cycles(3);
    check(16'(default_alloc_out), 16'h0000);
    acc(ACC_WRITE_ALLOC, 16'h0000, 1'b0, 2'b10);
    acc(ACC_WRITE_PROG, 16'h0000, 1'b0, 2'b01);
    acc(ACC_WRITE_MEM, RO_AREA_FIRST, 1'b0, 2'b01);
    @(posedge clk_in);
    protect_sw_in <= 1'b0;
    alloc_sw_in <= 1'b0;
    wait_cycles(3);
  endtask

  task t_run;
    go(MODE_RUN);
    check(16'({nh, tc, execute_out}), 16'h0007);
    for (int k = 1; k <= 3; k++) acc(access_type'(k), 16'h0010, 1'b0, 2'b01);
    acc(ACC_READ_MEM, 16'h0010, 1'b0, 2'b10);
    for (int k = 0; k < 4; k++) begin
      pulse(k);
      check(16'({refresh_out, refresh_kind_out}), 16'(4 + k));
    end
    wait_cycles(1);
    check(16'(refresh_out), 16'h0000);
    reg_wr(OFF_MODE_CTRL, 16'h0005);
    wait_cycles(3);
    check(16'(mode_out), 16'(MODE_RUN));
    reg_rd(OFF_MODE_CTRL);
    check(rd, 16'h0005);
  endtask

  task t_monitor_program;
    go(MODE_MONITOR);
    check(16'({nh, tc, execute_out}), 16'h0001);
    for (int k = 1; k <= 3; k++) acc(access_type'(k), 16'h0010, 1'b0, 2'b10);
    go(MODE_PROGRAM);
    check(16'({nh, tc, execute_out}), 16'h0004);
    reg_wr(OFF_MODE_CTRL, 16'h0007);
    pulse(0);
    wait_cycles(3);
    check(16'(mode_out), 16'(MODE_PROGRAM));
  endtask

  task t_hold_fatal;
    go(MODE_PROGRAM);
    reg_wr(OFF_SYS_CTRL, 16'h0001);
    go(MODE_RUN);
    check(16'(nh), 16'h0000);
    pulse(4);
    wait_cycles(1);
    check(16'({outputs_off_out, execute_out}), 16'h0002);
    reg_wr(OFF_SYS_CTRL, 16'h0003);
    wait_cycles(2);
    check(16'(outputs_off_out), 16'h0000);
    pulse(5);
    check(16'({log_write_out, log_slot_out}), 16'h0011);
    repeat (10) pulse(5);
    check(16'(log_write_out), 16'h0000);
    reg_rd(OFF_ERR_COUNT);
    check(rd, 16'(ERR_LOG_DEPTH));
  endtask

  // Resets in mid-run with the cassette switch on and expects one load pulse after release.
  task t_boot;
    @(posedge clk_in);
    cassette_sw_in <= 1'b1;
    rst_in <= 1'b1;
    wait_cycles(3);
    check(16'({cassette_load_out, default_alloc_out, mode_out}), 16'h0004);
    @(posedge clk_in);
    rst_in <= 1'b0;
    wait_cycles(1);
    check(16'(cassette_load_out), 16'h0001);
    wait_cycles(1);
    check(16'({cassette_load_out, mode_out}), 16'h0000);
    reg_rd(OFF_ERR_COUNT);
    check(rd, 16'h0000);
  endtask

  initial begin
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    t_program();
    t_run();
    t_monitor_program();
    term(1'b0, MODE_MONITOR);
    term(1'b1, MODE_RUN);
    t_hold_fatal();
    t_boot();
    stop_test();
  end

  // The whole sequence needs well under a thousand cycles; this limit is ten times that.
  initial begin
    #50000;
    fail_count++;
    stop_test();
  end
endmodule // tb_mode_policy
